// file: verilog/dcpr_readout.sv
/*
  read data path of the memory with the calibration-pattern readout mode.
  assumes command pins are sampled on the command clock, which is clk_sys_i,
  and that the array supplies rise and fall data in the cycles of a normal burst.
*/
module dcpr_readout (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic dram_reset_n_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [dcpr_pkg::BA_W-1:0] ba_i,
  input wire logic [dcpr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dcpr_pkg::LAT_W-1:0] cas_latency_i,
  input wire logic [dcpr_pkg::LAT_W-1:0] additive_latency_i,
  input wire logic [1:0] burst_mode_i,
  input wire logic [dcpr_pkg::DQ_W-1:0] array_rise_i,
  input wire logic [dcpr_pkg::DQ_W-1:0] array_fall_i,
  output logic [dcpr_pkg::DQ_W-1:0] dq_rise_o,
  output logic [dcpr_pkg::DQ_W-1:0] dq_fall_o,
  output logic dq_oe_o,
  output logic dqs_oe_o,
  output logic array_read_o,
  output logic array_write_o,
  output logic pattern_armed_o,
  output logic [dcpr_pkg::LOC_W-1:0] pattern_loc_o
);
  import dcpr_pkg::*;

  function automatic logic cmd_match(input logic [3:0] pins, input logic [3:0] code);
    return pins == code;
  endfunction

  function automatic logic pick_bit(input logic [PAT_W-1:0] pat, input logic [2:0] pos);
    return pat[pos];
  endfunction

  // ************************************************************
  // reset pin synchroniser and command decode
  // ************************************************************
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_meta <= 1'h0;
      rst_sync <= 1'h0;
    end else begin
      rst_meta <= dram_reset_n_i;
      rst_sync <= rst_meta;
    end
  end

  wire [3:0] cmd_pins = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire live = rst_sync;
  wire rd_take = live & cmd_match(cmd_pins, CMD_READ);
  wire wr_take = live & cmd_match(cmd_pins, CMD_WRITE);
  wire mr3_take = live & cmd_match(cmd_pins, CMD_MODE_SET) & (ba_i[1:0] == MR_SEL_THREE);

  // ************************************************************
  // mode register three: arm bit and location select
  // ************************************************************
  logic armed;
  logic [LOC_W-1:0] loc;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rst_sync) begin
      armed <= ARMED_RESET; // R6
      loc <= LOC_RESET;
    end else if (mr3_take) begin
      armed <= addr_i[ARM_BIT]; // R1
      loc <= addr_i[LOC_LSB +: LOC_W];
    end
  end

  logic [PAT_W-1:0] pattern;
  dcpr_pattern_store u_store (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .loc_i(loc),
    .pattern_o(pattern)
  );

  // ************************************************************
  // read tag and latency line
  // ************************************************************
  // only bit twelve and bit two matter; bank and other column bits are dropped
  wire chop_req = (burst_mode_i == BURST_FIXED_CHOP)
    | ((burst_mode_i == BURST_ON_THE_FLY) & ~addr_i[CHOP_SELECT_BIT]); // R13 R12
  wire half_req = chop_req & addr_i[HALF_BIT]; // R11 R10
  wire [TAG_W-1:0] next_tag = {rd_take, armed, chop_req, half_req}; // R3 R20

  // a shift line, not a counter, so reads may follow one another while earlier
  // bursts are still waiting out their latency
  logic [LINE_DEPTH-1:0][TAG_W-1:0] line;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rst_sync) begin
      line <= '0;
    end else begin
      line <= {line[LINE_DEPTH-2:0], next_tag};
    end
  end

  wire [RL_W-1:0] rl = RL_W'(additive_latency_i) + RL_W'(cas_latency_i); // R22
  wire [TAG_W-1:0] launch_tag = line[rl - LAUNCH_LEAD]; // R14
  wire [TAG_W-1:0] pre_tag = line[rl - PREAMBLE_LEAD];
  wire launch = launch_tag[TAG_VALID];

  // ************************************************************
  // burst engine
  // ************************************************************
  dcpr_state_t state;
  logic [1:0] beat;
  logic cur_pat;
  logic cur_chop;
  logic cur_half;

  wire last = (beat == (cur_chop ? CHOP_LAST_CLK : EIGHT_LAST_CLK));
  wire next_active = launch | ((state == DCPR_BURST) & ~last);
  wire [1:0] next_beat = launch ? 2'h0 : beat + 2'h1;
  wire next_pat = launch ? launch_tag[TAG_PAT] : cur_pat;
  wire next_chop = launch ? launch_tag[TAG_CHOP] : cur_chop;
  wire next_half = launch ? launch_tag[TAG_HALF] : cur_half;
  // position zero goes out first on the rising edge, as the low bit
  wire [2:0] pos_rise = {next_half | next_beat[1], next_beat[0], 1'b0}; // R16 R11
  wire [2:0] pos_fall = {next_half | next_beat[1], next_beat[0], 1'b1}; // R16
  wire bit_rise = pick_bit(pattern, pos_rise);
  wire bit_fall = pick_bit(pattern, pos_fall);
  wire [DQ_W-1:0] next_rise = next_pat ? {DQ_W{bit_rise}} : array_rise_i; // R8 R3 R7
  wire [DQ_W-1:0] next_fall = next_pat ? {DQ_W{bit_fall}} : array_fall_i; // R8

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rst_sync) begin
      state <= DCPR_IDLE;
      beat <= 2'h0;
      cur_pat <= 1'h0;
      cur_chop <= 1'h0;
      cur_half <= 1'h0;
    end else begin
      state <= next_active ? DCPR_BURST : DCPR_IDLE;
      beat <= next_beat;
      cur_pat <= next_pat;
      cur_chop <= next_chop;
      cur_half <= next_half;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rst_sync) begin
      dq_rise_o <= '0;
      dq_fall_o <= '0;
      dq_oe_o <= 1'h0;
      dqs_oe_o <= 1'h0;
      array_read_o <= 1'h0;
      array_write_o <= 1'h0;
    end else begin
      dq_rise_o <= next_active ? next_rise : '0;
      dq_fall_o <= next_active ? next_fall : '0;
      dq_oe_o <= next_active;
      dqs_oe_o <= next_active | pre_tag[TAG_VALID]; // R14
      array_read_o <= rd_take & ~armed; // R3 R7
      array_write_o <= wr_take & ~armed; // R7
    end
  end

  assign pattern_armed_o = armed;
  assign pattern_loc_o = loc;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_arm_on_mrs: assert property ( // R1
    mr3_take |=> pattern_armed_o == $past(addr_i[ARM_BIT])
      && pattern_loc_o == $past(addr_i[1:0]))
    else $error("arm bit or location not taken from mode register write");
  a_reset_disarms: assert property ( // R6
    !dram_reset_n_i ##1 !dram_reset_n_i |=> ##1 !pattern_armed_o && !dq_oe_o)
    else $error("reset pin did not clear the armed mode");
  a_read_source: assert property ( // R3
    rd_take && armed |=> !array_read_o)
    else $error("armed read reached the array");
  a_normal_array: assert property ( // R7
    (rd_take || wr_take) && !armed |=> array_read_o || array_write_o)
    else $error("normal access not passed to the array");
  a_lane_copy: assert property ( // R8
    dq_oe_o && cur_pat |-> dq_rise_o == {DQ_W{dq_rise_o[0]}}
      && dq_fall_o == {DQ_W{dq_fall_o[0]}})
    else $error("pattern bit not on every data line");
  a_read_latency: assert property ( // R22
    rd_take && rl == 5'h5 && $stable(rl) |-> ##4 dqs_oe_o ##1 dq_oe_o)
    else $error("burst not at read latency");
  a_full_burst: assert property ( // R10
    launch && !launch_tag[TAG_CHOP] && !line[rl - 5'h6][TAG_VALID] |=> dq_oe_o[*4] ##1 !dq_oe_o)
    else $error("eight-beat burst not four clocks long");
  a_pattern_order: assert property ( // R17
    launch && launch_tag[TAG_PAT] && pattern == PATTERN_CAL
      |=> !dq_rise_o[0] && dq_fall_o[0])
    else $error("calibration pattern order wrong");
  a_chop_half: assert property ( // R11
    launch && launch_tag[TAG_PAT] && launch_tag[TAG_HALF]
      |=> dq_rise_o[0] == $past(pattern[4]) && dq_fall_o[0] == $past(pattern[5]))
    else $error("upper chopped half not returned");
  a_repeat_reads: assert property ( // R20
    rd_take && armed |=> pattern_armed_o)
    else $error("read dropped the armed mode");

  c_arm: cover property (mr3_take && addr_i[ARM_BIT]);
  c_pattern_eight: cover property (launch && launch_tag[TAG_PAT] && !launch_tag[TAG_CHOP]);
  c_pattern_upper: cover property (launch && launch_tag[TAG_PAT] && launch_tag[TAG_HALF]);
  c_disarm: cover property (armed ##1 mr3_take && !addr_i[ARM_BIT]);

endmodule

// file: pkg/dcpr_pkg.sv
/*
  constants, types and the rule summary for the calibration-pattern readout path.
  assumes one command clock shared by the command pins and all block logic.
*/
// Behaviour
// R1: mode register set to register three with bit two high arms the pattern readout.
// R2: controller idles and precharges every bank before the arming command.
// R3: while armed, every read and auto-precharge read returns the selected pattern.
// R4: while armed, controller sends only reads until a disarming mode register set.
// R5: no power-down, self-refresh or non-read command while armed.
// R6: the active-low reset pin still works while armed.
// R7: with bit two low, reads and writes use the array, location bits ignored.
// R8: one-bit stream; every bit of both byte lanes carries the pattern bit.
// R9: controller drives column bits one and zero as 00 during pattern reads.
// R10: eight-beat pattern reads need column bit two low; order is zero to seven.
// R11: chopped reads give positions 0-3 for column bit two low, 4-7 when high.
// R12: bank bits, column bits 9-3, auto-precharge bit and bit 11 are ignored.
// R13: address bit twelve picks chop or full burst when on-the-fly is enabled.
// R14: pattern reads use ordinary read latency, preamble and output timing.
// R15: controller waits for delay-locked loop lock before pattern reads.
// R16: burst position zero is the pattern's least significant bit, seven the most.
// R17: location 00 returns 0,1,0,1,0,1,0,1, and 0,1,0,1 for either chopped half.
// R18: controller selects only location 00; other locations are reserved.
// R19: controller waits the pattern recovery time before reloading or disarming.
// R20: once armed, any number of reads return the pattern without re-arming.
// R21: controller waits command spacing and update delay after arm or disarm.
// R22: the burst starts a read latency, additive plus cas latency, after the read.
package dcpr_pkg;

  // ************************************************************
  // command pins {cs_n, ras_n, cas_n, we_n}
  // ************************************************************
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_MODE_SET = 4'h0;

  // ************************************************************
  // address and mode register fields
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int BA_W = 3;
  localparam logic [1:0] MR_SEL_THREE = 2'h3;
  localparam int ARM_BIT = 2;
  localparam int LOC_LSB = 0;
  localparam int LOC_W = 2;
  localparam int HALF_BIT = 2;
  localparam int CHOP_SELECT_BIT = 12;
  localparam logic ARMED_RESET = 1'h0;
  localparam logic [1:0] LOC_RESET = 2'h0;

  // mode_register_zero burst field
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;

  // ************************************************************
  // latency pipeline and burst timing
  // ************************************************************
  localparam int LAT_W = 4;
  localparam int RL_W = 5;
  localparam int LINE_DEPTH = 32;
  localparam int TAG_W = 4;
  localparam int TAG_VALID = 3;
  localparam int TAG_PAT = 2;
  localparam int TAG_CHOP = 1;
  localparam int TAG_HALF = 0;
  localparam logic [RL_W-1:0] LAUNCH_LEAD = 5'h2;
  localparam logic [RL_W-1:0] PREAMBLE_LEAD = 5'h3;
  localparam logic [1:0] EIGHT_LAST_CLK = 2'h3;
  localparam logic [1:0] CHOP_LAST_CLK = 2'h1;

  // ************************************************************
  // data lanes and pattern store
  // ************************************************************
  localparam int DQ_W = 16;
  localparam int PAT_W = 8;
  localparam int LOC_COUNT = 4;
  localparam logic [PAT_W-1:0] PATTERN_CAL = 8'haa;
  localparam logic [PAT_W-1:0] PATTERN_RESERVED = 8'h00;
  localparam logic [PAT_W-1:0] PATTERN_OUT_RESET = 8'h00;

  typedef enum logic [1:0] {
    DCPR_IDLE = 2'b01,
    DCPR_BURST = 2'b10
  } dcpr_state_t;

endpackage

// file: verilog/dcpr_pattern_store.sv
/*
  calibration pattern store: four locations of eight burst bits, read data registered.
  assumes the location select changes only between bursts.
*/
module dcpr_pattern_store (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [dcpr_pkg::LOC_W-1:0] loc_i,
  output logic [dcpr_pkg::PAT_W-1:0] pattern_o
);
  import dcpr_pkg::*;

  // ************************************************************
  // contents
  // ************************************************************
  // only location 00 is defined; reserved ones read a fixed filler
  logic [PAT_W-1:0] store [LOC_COUNT];
  assign store[0] = PATTERN_CAL; // R17
  assign store[1] = PATTERN_RESERVED;
  assign store[2] = PATTERN_RESERVED;
  assign store[3] = PATTERN_RESERVED;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pattern_o <= PATTERN_OUT_RESET;
    end else begin
      pattern_o <= store[loc_i]; // R3
    end
  end

endmodule

// file: testbench/dcpr_ctrl_model.sv
/*
  behavioural model of the memory controller that drives the command pins.
  assumes all banks are idle and the delay-locked loop is locked before it is used.
*/
module dcpr_ctrl_model (
  input wire logic clk_sys_i,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [dcpr_pkg::BA_W-1:0] ba_o,
  output logic [dcpr_pkg::ADDR_W-1:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dcpr_pkg::*;

  // ****************************************
  // command issue
  // ****************************************
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = 3'h0;
    addr_o = 16'h0000;
  end

  // one command per call; between commands the device is deselected and the
  // address flips, so a design that samples a stale address is caught
  task automatic issue(input logic [3:0] cmd, input logic [BA_W-1:0] ba,
                       input logic [ADDR_W-1:0] addr, input int settle);
    @(negedge clk_sys_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd;
    ba_o = ba;
    addr_o = addr;
    @(negedge clk_sys_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = ~ba;
    addr_o = ~addr;
    repeat (settle) @(negedge clk_sys_i);
  endtask
endmodule

// file: testbench/test_dram_calib_pattern_readout.sv
/*
  self-checking bench for the calibration-pattern readout path.
  assumes the controller model drives the command pins and the bench the rest.
*/
module test_dram_calib_pattern_readout;
  timeunit 1ns;
  timeprecision 1ns;
  import dcpr_pkg::*;

  // ****************************************
  // stimulus and design
  // ****************************************
  logic [3:0] cas_lat = 4'h6;
  logic [3:0] add_lat = 4'h1;
  localparam logic [15:0] ARR_R = 16'h3c5a;
  localparam logic [15:0] ARR_F = 16'hc3a5;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic dram_reset_n_i = 1'b1;
  logic [1:0] burst_mode = 2'h0;
  logic cs_n, ras_n, cas_n, we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_rise_o, dq_fall_o;
  logic dq_oe_o, dqs_oe_o, array_read_o, array_write_o, pattern_armed_o;
  logic [LOC_W-1:0] pattern_loc_o;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  dcpr_ctrl_model ctl (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));

  // read latency starts at seven, cas six plus additive one; latency test drops it to five
  dcpr_readout dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dram_reset_n_i(dram_reset_n_i),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
    .addr_i(addr), .cas_latency_i(cas_lat), .additive_latency_i(add_lat),
    .burst_mode_i(burst_mode), .array_rise_i(ARR_R), .array_fall_i(ARR_F),
    .dq_rise_o(dq_rise_o), .dq_fall_o(dq_fall_o), .dq_oe_o(dq_oe_o), .dqs_oe_o(dqs_oe_o),
    .array_read_o(array_read_o), .array_write_o(array_write_o),
    .pattern_armed_o(pattern_armed_o), .pattern_loc_o(pattern_loc_o));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // bank bits are all ones so a design that decodes them shows up
  task automatic check_read(input logic [15:0] a, input int clks, input logic armed);
    logic [15:0] er;
    logic [15:0] ef;
    int rl;
    er = armed ? 16'h0000 : ARR_R;
    ef = armed ? 16'hffff : ARR_F;
    rl = int'(cas_lat) + int'(add_lat);
    ctl.issue(CMD_READ, 3'h7, a, 0);
    // k counts clocks from the edge that took the read; issue returns mid-cycle one
    for (int k = 1; k < rl + 6; k++) begin
      check(16'(array_read_o), 16'(k == 1 && !armed), "array read");
      check(16'(dqs_oe_o), 16'(k >= rl - 1 && k < rl + clks), "strobe enable");
      check(16'(dq_oe_o), 16'(k >= rl && k < rl + clks), "data enable");
      if (k >= rl && k < rl + clks) begin
        check(dq_rise_o, er, "rise data");
        check(dq_fall_o, ef, "fall data");
      end
      @(negedge clk_sys_i);
    end
  endtask

  task automatic mode_set(input logic [15:0] a);
    ctl.issue(CMD_MODE_SET, 3'h3, a, 3);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_normal();
    check(16'(pattern_armed_o), 16'h0, "armed after reset");
    check_read(16'h1000, 4, 1'b0);
    ctl.issue(CMD_WRITE, 3'h0, 16'h0000, 0);
    check(16'(array_write_o), 16'h1, "array write");
    $display("test normal done");
  endtask

  task automatic t_armed();
    mode_set(16'h0004);
    check(16'(pattern_armed_o), 16'h1, "armed");
    check(16'(pattern_loc_o), 16'h0, "location");
    check_read(16'h1ff8, 4, 1'b1);
    check_read(16'h1000, 4, 1'b1);
    $display("test armed done");
  endtask

  task automatic t_chop();
    burst_mode = BURST_ON_THE_FLY;
    check_read(16'h0000, 2, 1'b1);
    check_read(16'h0004, 2, 1'b1);
    check_read(16'h1000, 4, 1'b1);
    burst_mode = BURST_FIXED_CHOP;
    check_read(16'h1004, 2, 1'b1);
    burst_mode = BURST_FIXED_EIGHT;
    $display("test chop done");
  endtask

  // latency changes only between reads; the design reads it every cycle to pick the line taps
  task automatic t_latency();
    cas_lat = 4'h5;
    add_lat = 4'h0;
    repeat (2) @(negedge clk_sys_i);
    check_read(16'h1ff8, 4, 1'b1);
    $display("test latency done");
  endtask

  task automatic t_reset_armed();
    check(16'(pattern_armed_o), 16'h1, "armed before reset pin");
    dram_reset_n_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check(16'(pattern_armed_o), 16'h0, "armed after reset pin");
    dram_reset_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    $display("test reset pin done");
  endtask

  task automatic t_disarm();
    mode_set(16'h0004);
    mode_set(16'h0003);
    check(16'(pattern_armed_o), 16'h0, "disarmed");
    check(16'(pattern_loc_o), 16'h3, "location while disarmed");
    check_read(16'h1000, 4, 1'b0);
    $display("test disarm done");
  endtask

  // a hang costs at most this many cycles; the full run needs under two hundred
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    t_normal();
    t_armed();
    t_chop();
    t_latency();
    t_reset_armed();
    t_disarm();
    conclude();
  end
endmodule
